// *** hdl/flash_ctl_defs.svh ***
`ifndef FLASH_CTL_DEFS_SVH
`define FLASH_CTL_DEFS_SVH

// apb register byte offsets
`define OFF_CTRL   8'h00
`define OFF_PROT   8'h04
`define OFF_TGT    8'h08
`define OFF_DATA   8'h0C
`define OFF_STAT   8'h10

// control field width in the low bits of the control word
`define CTRL_W     4

// nonvolatile byte values and addresses
`define NV_ERASED  8'hFF
`define NV_ALL_PROT 8'h00
`define PROT_ADDR  16'hFF80
`define TRIM_ADDR  16'hFFC0
`define VEC_PAGE   9'h1FF
`define TGT_RST    16'h8000
`define PAGE_LSB   7
`define FLASH_MSB  15

// apb answer values
`define RD_ZERO    32'h0000_0000

`endif

// *** hdl/flash_ctl_pkg.sv ***
package flash_ctl_pkg;

  // control register bits, low nibble of the word
  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } ctrl_s;

  // sequence tracker, gray along the normal path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SEL    = 3'h1,
    ST_PROTRD = 3'h3,
    ST_LATCH  = 3'h2,
    ST_HV     = 3'h6,
    ST_HOLD   = 3'h7
  } seq_e;

  // command towards the array macro
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        prog;
    logic        erase;
    logic        mass;
  } array_s;

endpackage : flash_ctl_pkg

// *** hdl/flash_nv_byte.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_defs.svh"

module flash_nv_byte (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // program and erase strobes
  input  wire logic       prog,
  input  wire logic       erase,
  input  wire logic [7:0] pdata,
  // stored byte
  output logic      [7:0] value_r
);

  // programming only clears bits; erase returns every bit to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_r <= `NV_ERASED;
    end else if (erase) begin
      value_r <= `NV_ERASED;
    end else if (prog) begin
      value_r <= value_r & pdata;
    end
  end

endmodule : flash_nv_byte
`default_nettype wire

// *** hdl/flash_prot_range.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_defs.svh"

module flash_prot_range (
  // protect byte and address under test
  input  wire logic [7:0]  prot,
  input  wire logic [15:0] addr,
  // decoded range
  output logic      [15:0] start,
  output logic             any_prot,
  output logic             hit
);

  // start is 1, protect bits, then a zero page offset; fe lands on ff00
  assign start    = {1'b1, prot, 7'h00};
  assign any_prot = (prot != `NV_ERASED);
  assign hit      = any_prot && addr[`FLASH_MSB] && (addr >= start);

endmodule : flash_prot_range
`default_nettype wire

// *** hdl/flash_ctl.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_defs.svh"

module flash_ctl (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // array control
  output flash_ctl_pkg::ctrl_s       ctrl_o,
  output flash_ctl_pkg::array_s      array_o,
  // nonvolatile trim byte as seen by the rest of the chip
  output logic      [7:0]            trim_o
);

  // state
  flash_ctl_pkg::ctrl_s  ctrl_r;
  flash_ctl_pkg::ctrl_s  ctrl_nxt;
  flash_ctl_pkg::seq_e   state_r;
  flash_ctl_pkg::seq_e   state_nxt;
  flash_ctl_pkg::array_s array_r;
  logic [15:0]           tgt_r;
  logic                  refused_r;
  logic [31:0]           prdata_r;
  logic                  pready_r;
  logic                  pslverr_r;
  logic [7:0]            prot_byte;
  logic [7:0]            trim_byte;

  // bus phase decode
  wire setup   = psel & ~penable;
  wire acc     = psel & penable & pready_r;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;

  // address decode
  wire hit_ctrl = (paddr == `OFF_CTRL);
  wire hit_prot = (paddr == `OFF_PROT);
  wire hit_tgt  = (paddr == `OFF_TGT);
  wire hit_data = (paddr == `OFF_DATA);
  wire hit_stat = (paddr == `OFF_STAT);
  wire mapped   = hit_ctrl | hit_prot | hit_tgt | hit_data | hit_stat;

  wire wr_ctrl  = wr & hit_ctrl;
  wire rd_prot  = rd & hit_prot;
  wire wr_tgt   = wr & hit_tgt & pwdata[`FLASH_MSB];
  wire wr_data  = wr & hit_data;

  // incoming control word
  flash_ctl_pkg::ctrl_s wr_c;
  assign wr_c = flash_ctl_pkg::ctrl_s'(pwdata[`CTRL_W-1:0]);

  // protected range for the latched target
  logic [15:0] prot_start;
  logic        any_prot;
  logic        tgt_hit;

  flash_prot_range u_range (
    .prot     (prot_byte),
    .addr     (tgt_r),
    .start    (prot_start),
    .any_prot (any_prot),
    .hit      (tgt_hit)
  );

  // a double mode request keeps both old mode bits, so neither bit can win a race; mass and high voltage still take the write
  wire both_req  = wr_c.erase & wr_c.program_select;
  wire erase_w   = both_req ? ctrl_r.erase : wr_c.erase;
  wire pgm_w     = both_req ? ctrl_r.program_select : wr_c.program_select;
  wire mode_on   = ctrl_r.erase | ctrl_r.program_select;
  wire mode_w    = erase_w | pgm_w;

  // mass erase is checked against the whole protect byte, page work
  // against the range holding the latched target
  wire mass_op   = ctrl_r.mass & ctrl_r.erase;
  wire blocked   = mass_op ? any_prot : tgt_hit;
  wire hv_ok     = (state_r == flash_ctl_pkg::ST_LATCH) & mode_on & mode_w & ~blocked;
  // only a write that tries to raise high voltage can report a refusal
  wire hv_try    = wr_ctrl & wr_c.high_voltage_enable & ~ctrl_r.high_voltage_enable;
  wire hv_set    = wr_c.high_voltage_enable & (ctrl_r.high_voltage_enable | hv_ok);

  // next control value; clearing high voltage always succeeds
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt.mass  = wr_c.mass;
      ctrl_nxt.erase = erase_w;
      ctrl_nxt.program_select   = pgm_w;
      ctrl_nxt.high_voltage_enable  = hv_set;
    end
  end

  // erase completes when the erase bit drops under high voltage
  wire erase_go  = (state_r == flash_ctl_pkg::ST_HV) & ctrl_r.high_voltage_enable & ctrl_r.erase
                   & ~ctrl_nxt.erase;
  wire vec_page  = (tgt_r[15:`PAGE_LSB] == `VEC_PAGE);
  // vector page shares the protect byte and trim byte, so both go
  wire erase_vec = erase_go & (ctrl_r.mass | vec_page);

  // a data write under high voltage programs the latched byte
  wire prog_go   = wr_data & (state_r == flash_ctl_pkg::ST_HV) & ctrl_r.high_voltage_enable
                   & ctrl_r.program_select;
  wire prog_prot = prog_go & (tgt_r == `PROT_ADDR);
  wire prog_trim = prog_go & (tgt_r == `TRIM_ADDR);

  // the two nonvolatile bytes that this block has to track
  flash_nv_byte u_prot (
    .pclk    (pclk),
    .presetn (presetn),
    .prog    (prog_prot),
    .erase   (erase_vec),
    .pdata   (pwdata[7:0]),
    .value_r (prot_byte)
  );

  flash_nv_byte u_trim (
    .pclk    (pclk),
    .presetn (presetn),
    .prog    (prog_trim),
    .erase   (erase_vec),
    .pdata   (pwdata[7:0]),
    .value_r (trim_byte)
  );

  // sequence tracker; dropping both mode bits before ST_HV abandons the sequence, in ST_HV it moves to ST_HOLD
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flash_ctl_pkg::ST_IDLE: begin
        if (wr_ctrl && mode_w) state_nxt = flash_ctl_pkg::ST_SEL;
      end
      flash_ctl_pkg::ST_SEL: begin
        if (!(ctrl_nxt.erase | ctrl_nxt.program_select)) state_nxt = flash_ctl_pkg::ST_IDLE;
        else if (rd_prot) state_nxt = flash_ctl_pkg::ST_PROTRD;
      end
      flash_ctl_pkg::ST_PROTRD: begin
        if (!(ctrl_nxt.erase | ctrl_nxt.program_select)) state_nxt = flash_ctl_pkg::ST_IDLE;
        else if (wr_tgt) state_nxt = flash_ctl_pkg::ST_LATCH;
      end
      flash_ctl_pkg::ST_LATCH: begin
        if (!(ctrl_nxt.erase | ctrl_nxt.program_select)) state_nxt = flash_ctl_pkg::ST_IDLE;
        else if (ctrl_nxt.high_voltage_enable) state_nxt = flash_ctl_pkg::ST_HV;
      end
      flash_ctl_pkg::ST_HV: begin
        if (!ctrl_nxt.high_voltage_enable) state_nxt = flash_ctl_pkg::ST_IDLE;
        else if (!(ctrl_nxt.erase | ctrl_nxt.program_select)) state_nxt = flash_ctl_pkg::ST_HOLD;
      end
      flash_ctl_pkg::ST_HOLD: begin
        if (!ctrl_nxt.high_voltage_enable) state_nxt = flash_ctl_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = flash_ctl_pkg::ST_IDLE;
      end
    endcase
  end

  // read mux, sampled in the setup cycle so prdata leaves a flop
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h000_0000, ctrl_r} :
    hit_prot ? {24'h00_0000, prot_byte} :
    hit_tgt  ? {16'h0000, tgt_r} :
    hit_stat ? {24'h00_0000, 3'h0, refused_r, any_prot, state_r} :
               `RD_ZERO;

  // bus answer: one wait-free access phase after every setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `RD_ZERO;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r  <= setup ? rd_mux : `RD_ZERO;
    end
  end

  // control, state and refusal flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= flash_ctl_pkg::ctrl_s'(4'h0);
      state_r   <= flash_ctl_pkg::ST_IDLE;
      refused_r <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      state_r   <= state_nxt;
      refused_r <= wr_ctrl ? (hv_try & ~hv_set) : refused_r;
    end
  end

  // target latch; in ST_HV it may move to any address with bit 15 set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_r <= `TGT_RST;
    end else if (wr_tgt && (state_r == flash_ctl_pkg::ST_PROTRD ||
                 state_r == flash_ctl_pkg::ST_HV)) begin
      tgt_r <= pwdata[15:0];
    end
  end

  // array command strobes are single-cycle pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_r <= flash_ctl_pkg::array_s'(27'h000_0000);
    end else begin
      array_r.addr  <= tgt_r;
      array_r.data  <= prog_go ? pwdata[7:0] : `NV_ERASED;
      array_r.prog  <= prog_go;
      array_r.erase <= erase_go;
      array_r.mass  <= ctrl_r.mass;
    end
  end

  // outputs straight from flops
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign ctrl_o  = ctrl_r;
  assign array_o = array_r;
  assign trim_o  = trim_byte;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mode_exclusive: assert property (
    !(ctrl_r.erase && ctrl_r.program_select))
    else $error("erase and program both set");

  a_double_dropped: assert property (
    wr_ctrl && both_req |=> ctrl_r.erase == $past(ctrl_r.erase) &&
                            ctrl_r.program_select == $past(ctrl_r.program_select))
    else $error("double mode write changed mode bits");

  a_high_voltage_enable_cause: assert property (
    $rose(ctrl_r.high_voltage_enable) |-> $past(state_r) == flash_ctl_pkg::ST_LATCH &&
                           $past(mode_on))
    else $error("high voltage rose outside latched sequence");

  a_high_voltage_enable_clear: assert property (
    wr_ctrl && !wr_c.high_voltage_enable |=> !ctrl_r.high_voltage_enable &&
                              (!$past(ctrl_r.high_voltage_enable) || state_r == flash_ctl_pkg::ST_IDLE))
    else $error("high voltage clear not honoured");

  a_protect_refuse: assert property (
    hv_try && !mass_op && tgt_hit |=> !ctrl_r.high_voltage_enable && refused_r)
    else $error("high voltage set on protected target");

  a_mass_locked: assert property (
    hv_try && mass_op && prot_byte != `NV_ERASED |=> !ctrl_r.high_voltage_enable)
    else $error("mass erase allowed while protected");

  a_prot_readonly: assert property (
    wr && hit_prot |=> $stable(prot_byte))
    else $error("protect byte changed by register write");

  a_vector_erase: assert property (
    erase_vec |=> prot_byte == `NV_ERASED && trim_byte == `NV_ERASED)
    else $error("vector page erase left protect or trim");

  a_range_edges: assert property (
    (prot_byte == `NV_ALL_PROT && tgt_r[`FLASH_MSB] |-> tgt_hit) and
    (prot_byte == `NV_ERASED |-> !tgt_hit))
    else $error("protect range edge wrong");

  a_fe_two_pages: assert property (
    prot_byte == 8'hFE |-> prot_start == 16'hFF00 &&
                           (tgt_hit == (tgt_r >= 16'hFF00)))
    else $error("fe protect range wrong");

  a_apb_answer: assert property (
    setup |=> pready ##1 !pready || (psel && !penable))
    else $error("apb answer timing wrong");

  a_unmapped_err: assert property (
    setup && !mapped |=> pready && pslverr)
    else $error("unmapped access not flagged");

  // high voltage lives only inside a started operation
  a_high_voltage_enable_state: assert property (
    ctrl_r.high_voltage_enable |-> state_r == flash_ctl_pkg::ST_HV || state_r == flash_ctl_pkg::ST_HOLD)
    else $error("high voltage on outside an operation");

  a_hv_has_mode: assert property (
    state_r == flash_ctl_pkg::ST_HV |-> ctrl_r.high_voltage_enable && mode_on)
    else $error("high voltage state without a mode bit");

  a_hold_high_voltage_enable: assert property (
    state_r == flash_ctl_pkg::ST_HOLD |-> ctrl_r.high_voltage_enable)
    else $error("hold state without high voltage");

  // array strobes carry the latched target and never fire without high voltage
  a_prog_strobe: assert property (
    prog_go |=> array_o.prog && array_o.addr == $past(tgt_r) &&
                array_o.data == $past(pwdata[7:0]))
    else $error("program strobe wrong");

  a_erase_strobe: assert property (
    erase_go |=> array_o.erase && array_o.mass == $past(ctrl_r.mass))
    else $error("erase strobe wrong");

  a_no_strobe_idle: assert property (
    !ctrl_r.high_voltage_enable |=> !array_o.prog && !array_o.erase)
    else $error("array strobe without high voltage");

  // programming can only clear protect bits, never set them
  a_prog_only_clears: assert property (
    prog_prot |=> prot_byte == ($past(prot_byte) & $past(pwdata[7:0])))
    else $error("protect byte program set a bit");

endmodule : flash_ctl
`default_nettype wire

// *** tb/flash_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_defs.svh"

module flash_cpu_model (
  // clock and slave answer
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // apb master request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  // minimum waits in 40 ns cycles, rounded up so none falls short
  localparam int NVS = 250;
  localparam int ERS = 25000;
  localparam int NVH = 125;
  localparam int RCV = 25;
  logic [31:0] rdata;
  logic        err;

  // bus idle at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer, request held until pready is seen high
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata   = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not look like a held request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer

  // mode, protect read, latching write, then high voltage; steps kept in order
  task hv_seq(input logic [3:0] mode, input logic [15:0] tgt);
    xfer(1'b1, `OFF_CTRL, {28'h000_0000, mode});
    xfer(1'b0, `OFF_PROT, 32'h0000_0000);
    xfer(1'b1, `OFF_TGT, {16'h0000, tgt});
    repeat (NVS) @(posedge pclk);
    xfer(1'b1, `OFF_CTRL, {28'h000_0000, 4'h8 | mode});
  endtask : hv_seq

  // drop the mode, hold, drop high voltage, recover
  task hv_off;
    xfer(1'b1, `OFF_CTRL, 32'h0000_0008);
    repeat (NVH) @(posedge pclk);
    xfer(1'b1, `OFF_CTRL, 32'h0000_0000);
    repeat (RCV) @(posedge pclk);
  endtask : hv_off

  task prog_byte(input logic [15:0] a, input logic [7:0] d);
    hv_seq(4'h1, a);
    repeat (NVH) @(posedge pclk);
    xfer(1'b1, `OFF_DATA, {24'h00_0000, d});
    hv_off();
  endtask : prog_byte

  task page_erase(input logic [15:0] a);
    hv_seq(4'h2, a);
    repeat (ERS) @(posedge pclk);
    hv_off();
  endtask : page_erase

  // whole-array erase, same ordered steps with mass and erase both set
  task mass_erase;
    hv_seq(4'h6, 16'h8000);
    repeat (ERS) @(posedge pclk);
    hv_off();
  endtask : mass_erase
endmodule : flash_cpu_model
`default_nettype wire

// *** tb/flash_erase_program_protect_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_ctl_defs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module flash_erase_program_protect_ctrl_tb;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr, trim_o;
  logic [31:0]            pwdata, prdata;
  flash_ctl_pkg::ctrl_s   ctrl_o;
  flash_ctl_pkg::array_s  array_o, last_prog, last_era;
  int                     fail_count = 0;
  int                     n_tests = 0;
  int                     n_prog = 0;
  int                     n_era = 0;

  always #20 pclk = ~pclk;

  flash_ctl flash_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ctrl_o(ctrl_o), .array_o(array_o), .trim_o(trim_o));
  flash_cpu_model flash_cpu_model_i (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // array strobes last one cycle, so catch them as they pass
  always @(posedge pclk) begin
    if (array_o.prog === 1'b1) begin
      n_prog++;
      last_prog = array_o;
    end
    if (array_o.erase === 1'b1) begin
      n_era++;
      last_era = array_o;
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d);
    flash_cpu_model_i.xfer(1'b1, a, d);
  endtask : wr

  task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    flash_cpu_model_i.xfer(1'b0, a, 32'h0000_0000);
    `CHK(n, e, flash_cpu_model_i.rdata)
  endtask : rd_chk

  task rd_bit(input string n, input int b, input logic e);
    flash_cpu_model_i.xfer(1'b0, `OFF_STAT, 32'h0000_0000);
    `CHK(n, e, flash_cpu_model_i.rdata[b])
  endtask : rd_bit

  task t_reset;
    rd_chk("ctrl", `OFF_CTRL, 32'h0000_0000);
    rd_chk("prot", `OFF_PROT, 32'h0000_00FF);
    `CHK("trim", 8'hFF, trim_o)
    wr(8'h14, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, flash_cpu_model_i.err)
    wr(`OFF_PROT, 32'h0000_0000);
    rd_chk("prot kept", `OFF_PROT, 32'h0000_00FF);
    rd_bit("any prot", 3, 1'b0);
  endtask : t_reset

  task t_modes;
    wr(`OFF_CTRL, 32'h0000_0003);
    rd_chk("both modes", `OFF_CTRL, 32'h0000_0000);
    wr(`OFF_CTRL, 32'h0000_0002);
    rd_chk("erase mode", `OFF_CTRL, 32'h0000_0002);
    wr(`OFF_CTRL, 32'h0000_0006);
    rd_chk("mass mode", `OFF_CTRL, 32'h0000_0006);
    wr(`OFF_CTRL, 32'h0000_0001);
    rd_chk("pgm mode", `OFF_CTRL, 32'h0000_0001);
    // high voltage without protect read and latching write
    wr(`OFF_CTRL, 32'h0000_0009);
    rd_bit("early hv refused", 4, 1'b1);
    `CHK("early hv", 1'b0, ctrl_o.high_voltage_enable)
    wr(`OFF_CTRL, 32'h0000_0000);
  endtask : t_modes

  task t_prog_erase;
    flash_cpu_model_i.prog_byte(16'hFFC0, 8'h5A);
    `CHK("prog addr", 16'hFFC0, last_prog.addr)
    `CHK("prog data", 8'h5A, last_prog.data)
    `CHK("trim prog", 8'h5A, trim_o)
    flash_cpu_model_i.page_erase(16'hFF80);
    `CHK("erase count", 1, n_era)
    `CHK("erase data", 8'hFF, last_era.data)
    `CHK("erase page", 1'b0, last_era.mass)
    `CHK("trim erased", 8'hFF, trim_o)
    rd_chk("prot erased", `OFF_PROT, 32'h0000_00FF);
    flash_cpu_model_i.prog_byte(16'hFFC0, 8'h3C);
    `CHK("prog count", 2, n_prog)
    `CHK("trim reprog", 8'h3C, trim_o)
    flash_cpu_model_i.mass_erase();
    `CHK("mass count", 2, n_era)
    `CHK("mass flag", 1'b1, last_era.mass)
    `CHK("mass trim", 8'hFF, trim_o)
  endtask : t_prog_erase

  task t_protect;
    flash_cpu_model_i.prog_byte(16'hFF80, 8'hFE);
    rd_chk("prot fe", `OFF_PROT, 32'h0000_00FE);
    rd_bit("any prot set", 3, 1'b1);
    flash_cpu_model_i.hv_seq(4'h1, 16'hFF00);
    rd_bit("ff00 refused", 4, 1'b1);
    `CHK("ff00 hv", 1'b0, ctrl_o.high_voltage_enable)
    wr(`OFF_CTRL, 32'h0000_0000);
    flash_cpu_model_i.hv_seq(4'h1, 16'hFEFF);
    @(posedge pclk);
    `CHK("feff hv", 1'b1, ctrl_o.high_voltage_enable)
    flash_cpu_model_i.hv_off();
    `CHK("hv cleared", 1'b0, ctrl_o.high_voltage_enable)
    flash_cpu_model_i.hv_seq(4'h6, 16'h8000);
    rd_bit("mass refused", 4, 1'b1);
    `CHK("mass hv", 1'b0, ctrl_o.high_voltage_enable)
    wr(`OFF_CTRL, 32'h0000_0000);
  endtask : t_protect

  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // cut a hang short, about twice the expected run
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_prog_erase();
    t_protect();
    complete_run();
  end
endmodule : flash_erase_program_protect_ctrl_tb
`default_nettype wire
